/* rtl/codec_ctrl_pkg.sv */
// constants for the codec control register bank
package codec_ctrl_pkg;
   // ==========================================
   // register offsets
   localparam logic [4:0] POWER_CONTROL_ADDR = 5'h00;
   localparam logic [4:0] RESERVED_ONE_ADDR = 5'h01;
   localparam logic [4:0] ADC_PORT_CLOCK_FORMAT_ADDR = 5'h02;
   localparam logic [4:0] DAC_PORT_CLOCK_FORMAT_ADDR = 5'h03;
   localparam logic [4:0] LAST_REG_ADDR = 5'h03;
   localparam logic [4:0] FIRST_REG_ADDR = 5'h00;
   localparam int REG_ADDR_WIDTH = 5;

   // ==========================================
   // field positions
   localparam int ADC_POWER_ON_BIT = 0;
   localparam int DAC_POWER_ON_BIT = 1;
   localparam int ADC_RATIO_LSB = 1;
   localparam int ADC_RATIO_MSB = 2;
   localparam int ADC_FORMAT_BIT = 4;
   localparam int DAC_SOFT_MUTE_BIT = 0;
   localparam int DAC_FORMAT_LSB = 1;
   localparam int DAC_FORMAT_MSB = 2;
   localparam int DEEMPHASIS_BIT = 3;
   localparam int DAC_SPEED_LSB = 4;
   localparam int DAC_SPEED_MSB = 5;
   localparam int DAC_AUTO_RATE_BIT = 6;

   // ==========================================
   // writable masks, fixed-zero bits read back as zero
   localparam logic [7:0] POWER_CONTROL_MASK = 8'h03;
   localparam logic [7:0] RESERVED_ONE_MASK = 8'h00;
   localparam logic [7:0] ADC_PORT_MASK = 8'h16;
   localparam logic [7:0] DAC_PORT_MASK = 8'h7f;

   // ==========================================
   // reset values
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] RESERVED_ONE_RESET = 8'h00;
   localparam logic [7:0] ADC_PORT_RESET = 8'h06;
   localparam logic [7:0] DAC_PORT_RESET = 8'h44;

   // ==========================================
   // dac sample codes
   localparam int SAMPLE_WIDTH = 24;
   localparam logic [23:0] DAC_POS_FULL_CODE = 24'h7fffff;
   localparam logic [23:0] DAC_NEG_FULL_CODE = 24'h800000;
   localparam logic [23:0] DAC_ZERO_CODE = 24'h000000;

   // ==========================================
   // speed modes
   typedef enum logic [1:0] {
      SPEED_NORMAL = 2'b00,
      SPEED_DOUBLE = 2'b01,
      SPEED_QUAD = 2'b10,
      SPEED_SPARE = 2'b11
   } speed_mode_e;
endpackage : codec_ctrl_pkg

/* rtl/pin_sync.sv */
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic pinIn,
   output logic pinOut
);
   // ==========================================
   // sync chain
   logic stage1_r;

   // first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stage1_r <= RESET_LEVEL;
         pinOut <= RESET_LEVEL;
      end else if (clkEn) begin
         stage1_r <= pinIn;
         pinOut <= stage1_r;
      end
   end
endmodule : pin_sync

/* rtl/codec_control_register_bank.sv */
// control register bank of the stereo codec, byte port from the serial engine
//
// Function
// - both powerdown pins low return every register to defaults.
// - adc pin low powers adc down, resets 01h-02h and adc power bit.
// - dac pin low powers dac down, resets 03h and dac power bit.
// - adc power bit zero powers adc down, keeps 01h-02h.
// - dac power bit zero powers dac down, keeps 03h.
// - 00h: adc power on at D0, dac at D1, default off, rest zero.
// - 02h D2:D1 adc master clock ratio, default binary 11.
// - 02h D4 adc port format, default zero.
// - 03h D0 dac soft mute, default off.
// - 03h D2:D1 dac format default 10, D3 de-emphasis default 0.
// - 03h D5:D4 dac speed used only when auto rate is zero.
// - 03h D6 dac auto rate, default one.
// - auto rate off still detects clock ratio inside chosen speed.
// - adc samples leave in two's complement.
// - dac takes 24-bit two's complement codes, 800000h negative full.
// - address counter increments per byte, wraps 03h to 00h.
`timescale 1ns/1ns
module codec_control_register_bank
   import codec_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic adcSidePowerdownPin_n,
   input wire logic dacSidePowerdownPin_n,
   input wire logic regAddrLoad,
   input wire logic [7:0] regAddrByte,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   input wire logic regReadAdvance,
   input wire logic [1:0] detectedSpeed,
   input wire logic [SAMPLE_WIDTH-1:0] adcSampleIn,
   input wire logic adcSampleValid,
   input wire logic [SAMPLE_WIDTH-1:0] dacSampleIn,
   input wire logic dacSampleValid,
   output logic [7:0] regRdData,
   output logic [REG_ADDR_WIDTH-1:0] regAddrCount,
   output logic adcPowered,
   output logic dacPowered,
   output logic [1:0] adcMasterRatioSelect,
   output logic adcPortFormat,
   output logic dacSoftMute,
   output logic [1:0] dacPortFormat,
   output logic deemphasisSelect,
   output logic dacAutoRate,
   output logic [1:0] dacSpeedMode,
   output logic dacSpeedFree,
   output logic [SAMPLE_WIDTH-1:0] adcSampleOut,
   output logic adcSampleOutValid,
   output logic signed [SAMPLE_WIDTH-1:0] dacLevel,
   output logic dacPosFull,
   output logic dacNegFull,
   output logic dacZero
);
   // ==========================================
   // helpers
   function automatic logic [REG_ADDR_WIDTH-1:0] nextAddr(
      input logic [REG_ADDR_WIDTH-1:0] a
   );
      // beyond the map the counter simply climbs and wraps at 5 bits
      if (a == LAST_REG_ADDR) begin
         nextAddr = FIRST_REG_ADDR;
      end else begin
         nextAddr = a + 5'h01;
      end
   endfunction : nextAddr

   function automatic logic [7:0] maskWrite(
      input logic [7:0] data,
      input logic [7:0] mask
   );
      maskWrite = data & mask;
   endfunction : maskWrite

   // one compare per target, so the write strobes cannot drift apart
   function automatic logic wrHit(
      input logic [REG_ADDR_WIDTH-1:0] a,
      input logic [REG_ADDR_WIDTH-1:0] target
   );
      wrHit = (a == target);
   endfunction : wrHit

   // ==========================================
   // pin synchronisers
   logic adcPinSync;
   logic dacPinSync;

   pin_sync #(
      .RESET_LEVEL(1'b1)
   ) adcPinSyncInst (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .pinIn(adcSidePowerdownPin_n),
      .pinOut(adcPinSync)
   );

   pin_sync #(
      .RESET_LEVEL(1'b1)
   ) dacPinSyncInst (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .pinIn(dacSidePowerdownPin_n),
      .pinOut(dacPinSync)
   );

   logic adcPinDown;
   logic dacPinDown;
   assign adcPinDown = ~adcPinSync;
   assign dacPinDown = ~dacPinSync;

   // ==========================================
   // address decode
   logic [REG_ADDR_WIDTH-1:0] addrCount_r;
   logic inMap;
   logic wrPower;
   logic wrAdc;
   logic wrDac;

   assign inMap = (addrCount_r <= LAST_REG_ADDR);
   // writes outside 00h-03h are dropped, the host must not make them
   assign wrPower = regWrite && wrHit(addrCount_r, POWER_CONTROL_ADDR);
   assign wrAdc = regWrite && wrHit(addrCount_r, ADC_PORT_CLOCK_FORMAT_ADDR);
   assign wrDac = regWrite && wrHit(addrCount_r, DAC_PORT_CLOCK_FORMAT_ADDR);

   // ==========================================
   // address counter
   always_ff @(posedge core_clk) begin
      if (reset) begin
         addrCount_r <= FIRST_REG_ADDR;
      end else if (clkEn) begin
         if (regAddrLoad) begin
            // top three address bits are don't care
            addrCount_r <= regAddrByte[REG_ADDR_WIDTH-1:0];
         end else if (regWrite || regReadAdvance) begin
            addrCount_r <= nextAddr(addrCount_r);
         end
      end
   end

   // ==========================================
   // power control register
   logic adcPowerOn_r;
   logic dacPowerOn_r;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         adcPowerOn_r <= POWER_CONTROL_RESET[ADC_POWER_ON_BIT];
      end else if (clkEn) begin
         if (adcPinDown) begin
            // both pins low also lands here, giving full defaults
            adcPowerOn_r <= POWER_CONTROL_RESET[ADC_POWER_ON_BIT];
         end else if (wrPower) begin
            adcPowerOn_r <= regWrData[ADC_POWER_ON_BIT];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dacPowerOn_r <= POWER_CONTROL_RESET[DAC_POWER_ON_BIT];
      end else if (clkEn) begin
         if (dacPinDown) begin
            dacPowerOn_r <= POWER_CONTROL_RESET[DAC_POWER_ON_BIT];
         end else if (wrPower) begin
            dacPowerOn_r <= regWrData[DAC_POWER_ON_BIT];
         end
      end
   end

   // ==========================================
   // adc port clock and format register
   logic [7:0] adcPortReg_r;

   // the power bit does not touch this register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         adcPortReg_r <= ADC_PORT_RESET;
      end else if (clkEn) begin
         if (adcPinDown) begin
            adcPortReg_r <= ADC_PORT_RESET;
         end else if (wrAdc) begin
            adcPortReg_r <= maskWrite(regWrData, ADC_PORT_MASK);
         end
      end
   end

   // ==========================================
   // dac port clock and format register
   logic [7:0] dacPortReg_r;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dacPortReg_r <= DAC_PORT_RESET;
      end else if (clkEn) begin
         if (dacPinDown) begin
            dacPortReg_r <= DAC_PORT_RESET;
         end else if (wrDac) begin
            dacPortReg_r <= maskWrite(regWrData, DAC_PORT_MASK);
         end
      end
   end

   // ==========================================
   // read data
   logic [7:0] rdMux;

   always_comb begin
      rdMux = 8'h00;
      case (addrCount_r)
         POWER_CONTROL_ADDR: begin
            rdMux = maskWrite({6'h00, dacPowerOn_r, adcPowerOn_r},
                              POWER_CONTROL_MASK);
         end
         RESERVED_ONE_ADDR: begin
            rdMux = RESERVED_ONE_RESET & RESERVED_ONE_MASK;
         end
         ADC_PORT_CLOCK_FORMAT_ADDR: begin
            rdMux = maskWrite(adcPortReg_r, ADC_PORT_MASK);
         end
         DAC_PORT_CLOCK_FORMAT_ADDR: begin
            rdMux = maskWrite(dacPortReg_r, DAC_PORT_MASK);
         end
         default: begin
            rdMux = 8'h00;
         end
      endcase
   end

   // registered, so data follows the counter by one cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         regRdData <= 8'h00;
         regAddrCount <= FIRST_REG_ADDR;
      end else if (clkEn) begin
         regRdData <= inMap ? rdMux : 8'h00;
         regAddrCount <= addrCount_r;
      end
   end

   // ==========================================
   // control outputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         adcPowered <= 1'b0;
         dacPowered <= 1'b0;
      end else if (clkEn) begin
         adcPowered <= adcPowerOn_r && !adcPinDown;
         dacPowered <= dacPowerOn_r && !dacPinDown;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         adcMasterRatioSelect <= ADC_PORT_RESET[ADC_RATIO_MSB:ADC_RATIO_LSB];
         adcPortFormat <= ADC_PORT_RESET[ADC_FORMAT_BIT];
      end else if (clkEn) begin
         adcMasterRatioSelect <= adcPortReg_r[ADC_RATIO_MSB:ADC_RATIO_LSB];
         adcPortFormat <= adcPortReg_r[ADC_FORMAT_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dacSoftMute <= DAC_PORT_RESET[DAC_SOFT_MUTE_BIT];
         dacPortFormat <= DAC_PORT_RESET[DAC_FORMAT_MSB:DAC_FORMAT_LSB];
         deemphasisSelect <= DAC_PORT_RESET[DEEMPHASIS_BIT];
         dacAutoRate <= DAC_PORT_RESET[DAC_AUTO_RATE_BIT];
      end else if (clkEn) begin
         dacSoftMute <= dacPortReg_r[DAC_SOFT_MUTE_BIT];
         dacPortFormat <= dacPortReg_r[DAC_FORMAT_MSB:DAC_FORMAT_LSB];
         deemphasisSelect <= dacPortReg_r[DEEMPHASIS_BIT];
         dacAutoRate <= dacPortReg_r[DAC_AUTO_RATE_BIT];
      end
   end

   // ==========================================
   // dac speed mode selection
   logic [1:0] manualSpeed;
   assign manualSpeed = dacPortReg_r[DAC_SPEED_MSB:DAC_SPEED_LSB];

   // ratio detection always runs, only the speed choice is pinned
   always_ff @(posedge core_clk) begin
      if (reset) begin
         dacSpeedMode <= SPEED_NORMAL;
         dacSpeedFree <= DAC_PORT_RESET[DAC_AUTO_RATE_BIT];
      end else if (clkEn) begin
         if (dacPortReg_r[DAC_AUTO_RATE_BIT]) begin
            dacSpeedMode <= detectedSpeed;
            dacSpeedFree <= 1'b1;
         end else begin
            dacSpeedMode <= manualSpeed;
            dacSpeedFree <= 1'b0;
         end
      end
   end

   // ==========================================
   // adc sample output
   // zero data while powered down, coding passes through unchanged
   always_ff @(posedge core_clk) begin
      if (reset) begin
         adcSampleOut <= DAC_ZERO_CODE;
         adcSampleOutValid <= 1'b0;
      end else if (clkEn) begin
         adcSampleOutValid <= adcSampleValid;
         if (!adcPowered) begin
            // a stale sample must not linger once the path is powered down
            adcSampleOut <= DAC_ZERO_CODE;
         end else if (adcSampleValid) begin
            adcSampleOut <= adcSampleIn;
         end
      end
   end

   // ==========================================
   // dac sample interpretation
   always_ff @(posedge core_clk) begin
      if (reset) begin
         dacLevel <= '0;
         dacPosFull <= 1'b0;
         dacNegFull <= 1'b0;
         dacZero <= 1'b1;
      end else if (clkEn) begin
         if (!dacPowered) begin
            dacLevel <= '0;
            dacPosFull <= 1'b0;
            dacNegFull <= 1'b0;
            dacZero <= 1'b1;
         end else if (dacSampleValid) begin
            dacLevel <= $signed(dacSampleIn);
            dacPosFull <= (dacSampleIn == DAC_POS_FULL_CODE);
            dacNegFull <= (dacSampleIn == DAC_NEG_FULL_CODE);
            dacZero <= (dacSampleIn == DAC_ZERO_CODE);
         end
      end
   end
endmodule : codec_control_register_bank

/* verif/codec_ctrl_monitor.sv */
// port-level checks for the codec control register bank
`timescale 1ns/1ns
module codec_ctrl_monitor
   import codec_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic adcSidePowerdownPin_n,
   input wire logic dacSidePowerdownPin_n,
   input wire logic regAddrLoad,
   input wire logic [1:0] detectedSpeed,
   input wire logic [SAMPLE_WIDTH-1:0] adcSampleIn,
   input wire logic adcSampleValid,
   input wire logic [SAMPLE_WIDTH-1:0] dacSampleIn,
   input wire logic dacSampleValid,
   input wire logic [7:0] regRdData,
   input wire logic [REG_ADDR_WIDTH-1:0] regAddrCount,
   input wire logic adcPowered,
   input wire logic dacPowered,
   input wire logic dacAutoRate,
   input wire logic [1:0] dacSpeedMode,
   input wire logic [SAMPLE_WIDTH-1:0] adcSampleOut,
   input wire logic signed [SAMPLE_WIDTH-1:0] dacLevel,
   input wire logic dacPosFull,
   input wire logic dacNegFull,
   input wire logic dacZero
);
   // ==========================================
   // sequences and assertions
   default clocking monClk @(posedge core_clk);
   endclocking
   default disable iff (reset);
   sequence adcLowRun;
      (!adcSidePowerdownPin_n && clkEn) [*4];
   endsequence
   sequence dacLowRun;
      (!dacSidePowerdownPin_n && clkEn) [*4];
   endsequence
   sequence negCodeIn;
      dacSampleValid && clkEn && dacPowered && (dacSampleIn == DAC_NEG_FULL_CODE);
   endsequence
   // four synced edges cover the two-flop pin path
   adc_pin_off_a: assert property (adcLowRun |=> !adcPowered)
      else $error("adc powered with its pin low");
   dac_pin_off_a: assert property (dacLowRun |=> !dacPowered)
      else $error("dac powered with its pin low");
   auto_speed_a: assert property (dacAutoRate && $past(dacAutoRate) && $past(clkEn)
      && !$past(reset) |-> dacSpeedMode == $past(detectedSpeed))
      else $error("auto rate speed not taken from detector");
   adc_sample_a: assert property (adcSampleValid && clkEn && adcPowered ##1 adcPowered
      |-> adcSampleOut == $past(adcSampleIn))
      else $error("adc sample not passed unchanged");
   dac_forced_a: assert property (!dacPowered ##1 !dacPowered
      |-> dacZero && !dacPosFull && !dacNegFull && dacLevel == 0)
      else $error("dac output not forced while powered down");
   dac_negfull_a: assert property (negCodeIn ##1 dacPowered
      |-> dacNegFull && !dacPosFull && !dacZero)
      else $error("negative full code misclassified");
   rsvd_read_a: assert property (regAddrCount > LAST_REG_ADDR |-> regRdData == 8'h00)
      else $error("unmapped read not zero");
   addr_wrap_a: assert property ($past(regAddrCount) == 5'h03 && regAddrCount != 5'h03
      && !$past(regAddrLoad, 2) && !$past(reset) |-> regAddrCount == 5'h00)
      else $error("address counter did not wrap to zero");
   adc_zero_a: assert property (!adcPowered && clkEn |=> adcSampleOut == 24'h000000)
      else $error("adc data not zero while powered down");
endmodule : codec_ctrl_monitor

bind codec_control_register_bank codec_ctrl_monitor MON (
   .core_clk(core_clk), .reset(reset), .clkEn(clkEn),
   .adcSidePowerdownPin_n(adcSidePowerdownPin_n), .dacSidePowerdownPin_n(dacSidePowerdownPin_n),
   .regAddrLoad(regAddrLoad), .detectedSpeed(detectedSpeed), .adcSampleIn(adcSampleIn),
   .adcSampleValid(adcSampleValid), .dacSampleIn(dacSampleIn), .dacSampleValid(dacSampleValid),
   .regRdData(regRdData), .regAddrCount(regAddrCount), .adcPowered(adcPowered),
   .dacPowered(dacPowered), .dacAutoRate(dacAutoRate), .dacSpeedMode(dacSpeedMode),
   .adcSampleOut(adcSampleOut), .dacLevel(dacLevel), .dacPosFull(dacPosFull),
   .dacNegFull(dacNegFull), .dacZero(dacZero)
);

/* verif/codec_host_model.sv */
// byte-port host standing in for the serial bus engine
`timescale 1ns/1ns
module codec_host_model
   import codec_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] regRdData,
   output logic regAddrLoad,
   output logic [7:0] regAddrByte,
   output logic regWrite,
   output logic [7:0] regWrData,
   output logic regReadAdvance
);
   // ==========================================
   // byte transfers, one request held for one edge
   logic [4:0] addr = 5'h00;
   initial begin
      regAddrLoad = 1'b0;
      regAddrByte = 8'h00;
      regWrite = 1'b0;
      regWrData = 8'h00;
      regReadAdvance = 1'b0;
   end
   task automatic setAddr(input logic [7:0] a);
      @(posedge core_clk);
      #1;
      regAddrLoad = 1'b1;
      regAddrByte = a;
      addr = a[4:0];
      @(posedge core_clk);
      #1;
      regAddrLoad = 1'b0;
      regAddrByte = ~a;
   endtask : setAddr
   // rude skips the fixed-zero masking, used only to probe discard
   task automatic wrByte(input logic [7:0] d, input logic rude);
      logic [7:0] keep;
      case (addr)
         5'h00: keep = POWER_CONTROL_MASK;
         5'h02: keep = ADC_PORT_MASK;
         5'h03: keep = DAC_PORT_MASK;
         default: keep = RESERVED_ONE_MASK;
      endcase
      if (rude) keep = 8'hff;
      if (addr <= LAST_REG_ADDR || rude) begin
         @(posedge core_clk);
         #1;
         regWrite = 1'b1;
         regWrData = d & keep;
         @(posedge core_clk);
         #1;
         regWrite = 1'b0;
         regWrData = ~(d & keep);
         addr = (addr == LAST_REG_ADDR) ? FIRST_REG_ADDR : addr + 5'h01;
      end
   endtask : wrByte
   task automatic rdByte(output logic [7:0] d);
      @(posedge core_clk);
      #1;
      d = regRdData;
      regReadAdvance = 1'b1;
      @(posedge core_clk);
      #1;
      regReadAdvance = 1'b0;
      addr = (addr == LAST_REG_ADDR) ? FIRST_REG_ADDR : addr + 5'h01;
   endtask : rdByte
endmodule : codec_host_model

/* verif/codec_control_register_bank_tb_top.sv */
// self-checking bench for the codec control register bank
`timescale 1ns/1ns
module codec_control_register_bank_tb_top
   import codec_ctrl_pkg::*;
();
   // ==========================================
   // bench signals and instances
   logic core_clk, reset, clkEn, adcPin_n, dacPin_n, adcValid, dacValid;
   logic regAddrLoad, regWrite, regReadAdvance, adcSampleOutValid;
   logic adcPowered, dacPowered, adcPortFormat, dacSoftMute, deemphasisSelect;
   logic dacAutoRate, dacSpeedFree, dacPosFull, dacNegFull, dacZero;
   logic [1:0] detectedSpeed, adcMasterRatioSelect, dacPortFormat, dacSpeedMode;
   logic [7:0] regAddrByte, regWrData, regRdData, b;
   logic [4:0] regAddrCount;
   logic [23:0] adcIn, dacIn, adcSampleOut;
   logic signed [23:0] dacLevel;
   logic [23:0] codes [3] = '{DAC_POS_FULL_CODE, DAC_NEG_FULL_CODE, DAC_ZERO_CODE};
   logic [2:0] flags [3] = '{3'b100, 3'b010, 3'b001};
   int numErrors = 0;
   int checks = 0;
   codec_control_register_bank DUT (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
      .adcSidePowerdownPin_n(adcPin_n), .dacSidePowerdownPin_n(dacPin_n),
      .regAddrLoad(regAddrLoad), .regAddrByte(regAddrByte), .regWrite(regWrite),
      .regWrData(regWrData), .regReadAdvance(regReadAdvance), .detectedSpeed(detectedSpeed),
      .adcSampleIn(adcIn), .adcSampleValid(adcValid), .dacSampleIn(dacIn),
      .dacSampleValid(dacValid), .regRdData(regRdData), .regAddrCount(regAddrCount),
      .adcPowered(adcPowered), .dacPowered(dacPowered), .adcPortFormat(adcPortFormat),
      .adcMasterRatioSelect(adcMasterRatioSelect), .dacSoftMute(dacSoftMute),
      .dacPortFormat(dacPortFormat), .deemphasisSelect(deemphasisSelect),
      .dacAutoRate(dacAutoRate), .dacSpeedMode(dacSpeedMode), .dacSpeedFree(dacSpeedFree),
      .adcSampleOut(adcSampleOut), .adcSampleOutValid(adcSampleOutValid),
      .dacLevel(dacLevel), .dacPosFull(dacPosFull), .dacNegFull(dacNegFull), .dacZero(dacZero));
   codec_host_model HOST (.core_clk(core_clk), .regRdData(regRdData),
      .regAddrLoad(regAddrLoad), .regAddrByte(regAddrByte), .regWrite(regWrite),
      .regWrData(regWrData), .regReadAdvance(regReadAdvance));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         numErrors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      $display("errors %0d checks %0d", numErrors, checks);
      if (numErrors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // reads 00h to 03h in one run, first register in the top byte
   task automatic regsChk(input logic [31:0] e);
      HOST.setAddr(8'h00);
      for (int i = 3; i >= 0; i--) begin
         HOST.rdByte(b);
         chk(b, e[i*8 +: 8]);
      end
   endtask : regsChk
   // pins held well past the two-flop sync, then released
   task automatic pins(input logic a, input logic d);
      @(posedge core_clk);
      #1;
      adcPin_n = a;
      dacPin_n = d;
      repeat (8) @(posedge core_clk);
      #1;
      adcPin_n = 1'b1;
      dacPin_n = 1'b1;
      repeat (8) @(posedge core_clk);
   endtask : pins
   task automatic samp(input logic [23:0] code);
      @(posedge core_clk);
      #1;
      adcIn = code ^ 24'h5a5a5a;
      dacIn = code;
      adcValid = 1'b1;
      dacValid = 1'b1;
      @(posedge core_clk);
      #1;
      adcValid = 1'b0;
      dacValid = 1'b0;
      dacIn = ~code;
      chk(adcSampleOutValid, 1'b1);
      @(posedge core_clk);
      #1;
      chk(adcSampleOutValid, 1'b0);
   endtask : samp
   task automatic wr4(input logic [7:0] a, input logic [7:0] d);
      HOST.setAddr(a);
      HOST.wrByte(d, 1'b0);
      repeat (2) @(posedge core_clk);
      #1;
   endtask : wr4
   initial begin
      #200000;
      numErrors++;
      results();
   end
   initial begin
      {reset, clkEn, adcPin_n, dacPin_n} = 4'hf;
      {adcValid, dacValid, adcIn, dacIn} = '0;
      detectedSpeed = 2'b01;
      repeat (16) @(posedge core_clk);
      #1;
      reset = 1'b0;
      regsChk(32'h00000644);
      HOST.rdByte(b);
      chk(b, 8'h00);
      chk(regAddrCount, 5'h00);
      chk({adcMasterRatioSelect, dacPortFormat, dacAutoRate, dacZero, adcPowered, dacPowered},
         {2'b11, 2'b10, 4'b1100});
      HOST.setAddr(8'h03);
      HOST.wrByte(8'h0d, 1'b0);
      HOST.wrByte(8'h03, 1'b0);
      HOST.wrByte(8'h00, 1'b0);
      HOST.wrByte(8'h10, 1'b0);
      regsChk(32'h0300100d);
      chk({dacSoftMute, dacPortFormat, deemphasisSelect, dacAutoRate, dacSpeedFree, adcPortFormat,
         adcMasterRatioSelect, adcPowered, dacPowered}, 11'b1_10_1_00_1_00_11);
      for (int i = 0; i < 3; i++) begin
         samp(codes[i]);
         chk({dacLevel, dacPosFull, dacNegFull, dacZero}, {codes[i], flags[i]});
         chk(adcSampleOut, codes[i] ^ 24'h5a5a5a);
      end
      wr4(8'h03, 8'h2d);
      chk({dacSpeedMode, dacSpeedFree}, 3'b100);
      wr4(8'h03, 8'h6d);
      chk({dacSpeedMode, dacSpeedFree}, 3'b011);
      HOST.setAddr(8'h01);
      repeat (3) HOST.wrByte(8'hff, 1'b1);
      wr4(8'h00, 8'h00);
      regsChk(32'h0000167f);
      chk({adcPowered, dacPowered}, 2'b00);
      chk(adcSampleOut, 24'h000000);
      HOST.setAddr(8'h05);
      HOST.rdByte(b);
      chk(b, 8'h00);
      // a write while the enable is low must leave everything frozen
      HOST.setAddr(8'h02);
      clkEn = 1'b0;
      HOST.wrByte(8'h00, 1'b0);
      clkEn = 1'b1;
      regsChk(32'h0000167f);
      wr4(8'h00, 8'h03);
      pins(1'b0, 1'b1);
      regsChk(32'h0200067f);
      chk({adcPowered, dacPowered}, 2'b01);
      pins(1'b1, 1'b0);
      regsChk(32'h00000644);
      wr4(8'h00, 8'h03);
      wr4(8'h02, 8'h10);
      wr4(8'h03, 8'h0d);
      detectedSpeed = 2'b10;
      pins(1'b0, 1'b0);
      regsChk(32'h00000644);
      chk({dacSpeedMode, dacSpeedFree, dacAutoRate}, 4'b1011);
      results();
   end
endmodule : codec_control_register_bank_tb_top
